// *** src/ledpc_pkg.sv ***
/*
 * ledpc_pkg: shared constants and carriers for the led and pin
 * configuration block (pins 8, 9 and 10).
 * assumes: one 20 mhz clock domain; apb register access.
 */
package ledpc_pkg;

    // ======================================================
    // register map
    localparam logic [11:0] LPC_CFG_ADDR = 12'h024;
    localparam int LPC_ADDR_W = 12;
    localparam int LPC_DATA_W = 32;

    // ======================================================
    // field positions in led_and_pin_config
    localparam int LPC_LED_MAPPING_SELECT_BIT = 31;
    localparam int LPC_FN10_LSB = 24;
    localparam int LPC_FN9_LSB = 20;
    localparam int LPC_FN8_LSB = 16;
    localparam int LPC_BUF_LSB = 8;
    localparam int LPC_DIR_LSB = 4;
    localparam int LPC_DATA_LSB = 0;
    localparam int LPC_NPINS = 3;

    // ======================================================
    // reset values
    localparam logic [1:0] LPC_FN_RESET = 2'h0;
    localparam logic [2:0] LPC_BUF_RESET = 3'h0;
    localparam logic [2:0] LPC_DIR_RESET = 3'h0;
    localparam logic LPC_LED_MAPPING_SELECT_RESET = 1'b0;
    // cycles after reset before the wake edge detector is trusted
    localparam logic [1:0] LPC_WAKE_SETTLE = 2'h3;

    // ======================================================
    // pin function codes
    localparam logic [1:0] LPC_FN_GPIO = 2'h0;
    localparam logic [1:0] LPC_FN_LED = 2'h1;
    localparam logic [1:0] LPC_FN_MIRROR_A = 2'h2;
    localparam logic [1:0] LPC_FN_MIRROR_B = 2'h3;

    // ======================================================
    // carriers
    typedef struct packed {
        logic led_mapping_select;
        logic [1:0] pin10_function;
        logic [1:0] pin9_function;
        logic [1:0] pin8_function;
        logic [2:0] pin_buffer_type;
        logic [2:0] pin_direction;
        logic [2:0] pin_data;
    } ledpc_cfg_s;

    typedef struct packed {
        logic speed;
        logic link;
        logic activity;
    } ledpc_status_s;

    typedef struct packed {
        logic [3:0] rxd;
        logic crs;
        logic phy_reset_low_mirror;
    } ledpc_mii_s;

endpackage

// *** src/ledpc_sync.sv ***
/*
 * ledpc_sync: two flip-flop synchroniser for pin levels.
 * assumes: inputs are asynchronous to mclk_in; only the second
 * stage may be read by other logic.
 */
`timescale 1ns/10ps

module ledpc_sync #(
    parameter int WIDTH = 3
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    import ledpc_pkg::*;

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;

endmodule

// *** src/ledpc_top.sv ***
/*
 * ledpc_top: configuration and pin drivers for pins 8, 9 and 10,
 * with led mapping and mii diagnostic mirrors, behind an apb slave.
 * assumes: led status, mii and reset pulses come from logic on
 * mclk_in; pin levels arrive asynchronously; pin bit 0 is pin 8.
 */
// Register access over APB is this design's own decision.
`timescale 1ns/10ps

// How it works
// - wake needs wake-enable and input direction
// - bit 31 picks led mapping
// - mapping 0 second led shows link without activity
// - mapping bit resets 0, eeprom loads it
// - usb/lite reset restores eeprom image value
// - pin 10 function field bits 25:24
// - pin 9 function field bits 21:20
// - pin 8 function field bits 17:16
// - led code drives mapped indicator
// - mirror code drives internal signal continuously
// - buffer bits: set push-pull, clear open-drain
// - direction bits: set output, clear input
// - data drives output, reads live pin
// - data field reads pins after reset
module ledpc_top (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ledpc_pkg::LPC_ADDR_W-1:0] paddr_in,
    input wire logic [ledpc_pkg::LPC_DATA_W-1:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic pready_out,
    output logic pslverr_out,
    output logic [ledpc_pkg::LPC_DATA_W-1:0] prdata_out,
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe_out,
    input wire ledpc_pkg::ledpc_status_s status_in,
    input wire ledpc_pkg::ledpc_mii_s mii_in,
    input wire logic [2:0] wake_enable_in,
    input wire logic eeprom_load_in,
    input wire logic eeprom_present_in,
    input wire logic eeprom_led_select_in,
    input wire logic usb_reset_in,
    input wire logic lite_reset_in,
    output logic wake_event_out
);
    import ledpc_pkg::*;

    // ======================================================
    // pin driver helper
    // returns {level, enable}; active-low leds and mirrors use
    // the same buffer decision so one function covers all pins
    function automatic logic [1:0] pin_drive(
        input logic [1:0] fn,
        input logic buf_pp,
        input logic dir_out,
        input logic data,
        input logic led_level,
        input logic mirror_a,
        input logic mirror_b
    );
        logic lvl;
        logic drv;
        lvl = data;
        drv = (fn != LPC_FN_GPIO) || dir_out;
        unique case (fn)
            LPC_FN_GPIO: lvl = data;
            LPC_FN_LED: lvl = led_level;
            LPC_FN_MIRROR_A: lvl = mirror_a;
            LPC_FN_MIRROR_B: lvl = mirror_b;
        endcase
        // open-drain only ever pulls low
        if (!drv)
            pin_drive = 2'h0;
        else if (buf_pp)
            pin_drive = {lvl, 1'b1};
        else
            pin_drive = {1'b0, ~lvl};
    endfunction

    // ======================================================
    // state
    ledpc_cfg_s cfg_reg;
    logic image_sel_reg;
    logic image_valid_reg;
    logic [2:0] pin_lvl;
    logic [2:0] pin_prev_reg;
    logic [1:0] settle_reg;
    logic [2:0] wake_hits;
    logic [1:0] drv10;
    logic [1:0] drv9;
    logic [1:0] drv8;
    logic led_pin9_level;
    logic led_pin8_level;
    logic access;
    logic hit;
    logic done;
    logic [LPC_DATA_W-1:0] rd_word;
    logic [LPC_DATA_W-1:0] wmask;

    ledpc_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .d_in(pin_in),
        .q_out(pin_lvl)
    );

    // ======================================================
    // apb slave: one wait state, then pready
    assign access = psel_in && penable_in;
    assign hit = (paddr_in == LPC_CFG_ADDR);
    assign done = access && pready_out;

    always_comb
    begin
        rd_word = '0;
        rd_word[LPC_LED_MAPPING_SELECT_BIT] = cfg_reg.led_mapping_select;
        rd_word[LPC_FN10_LSB +: 2] = cfg_reg.pin10_function;
        rd_word[LPC_FN9_LSB +: 2] = cfg_reg.pin9_function;
        rd_word[LPC_FN8_LSB +: 2] = cfg_reg.pin8_function;
        rd_word[LPC_BUF_LSB +: 3] = cfg_reg.pin_buffer_type;
        rd_word[LPC_DIR_LSB +: 3] = cfg_reg.pin_direction;
        rd_word[LPC_DATA_LSB +: 3] = pin_lvl;
    end

    assign wmask = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}},
        {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};

    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= '0;
        end
        else if (access && !pready_out)
        begin
            pready_out <= 1'b1;
            pslverr_out <= !hit;
            prdata_out <= (hit && !pwrite_in) ? rd_word : '0;
        end
        else
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end

    // ======================================================
    // eeprom image of the mapping bit
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            image_sel_reg <= LPC_LED_MAPPING_SELECT_RESET;
            image_valid_reg <= 1'b0;
        end
        else if (eeprom_load_in)
        begin
            image_sel_reg <= eeprom_led_select_in;
            image_valid_reg <= eeprom_present_in;
        end
    end

    // ======================================================
    // configuration register
    // a usb or lite reset outranks a software write in the same
    // cycle, so the mapping never leaves a reset half-restored
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            cfg_reg <= '{LPC_LED_MAPPING_SELECT_RESET, LPC_FN_RESET, LPC_FN_RESET,
                LPC_FN_RESET, LPC_BUF_RESET, LPC_DIR_RESET,
                3'h0};
        end
        else
        begin
            if (done && hit && pwrite_in)
            begin
                if (wmask[LPC_LED_MAPPING_SELECT_BIT])
                    cfg_reg.led_mapping_select <=
                        pwdata_in[LPC_LED_MAPPING_SELECT_BIT];
                if (wmask[LPC_FN10_LSB])
                    cfg_reg.pin10_function <=
                        pwdata_in[LPC_FN10_LSB +: 2];
                if (wmask[LPC_FN9_LSB])
                    cfg_reg.pin9_function <=
                        pwdata_in[LPC_FN9_LSB +: 2];
                if (wmask[LPC_FN8_LSB])
                    cfg_reg.pin8_function <=
                        pwdata_in[LPC_FN8_LSB +: 2];
                if (wmask[LPC_BUF_LSB])
                    cfg_reg.pin_buffer_type <=
                        pwdata_in[LPC_BUF_LSB +: 3];
                if (wmask[LPC_DIR_LSB])
                    cfg_reg.pin_direction <=
                        pwdata_in[LPC_DIR_LSB +: 3];
                if (wmask[LPC_DATA_LSB])
                    cfg_reg.pin_data <=
                        pwdata_in[LPC_DATA_LSB +: 3];
            end
            if (usb_reset_in || lite_reset_in)
                cfg_reg.led_mapping_select <=
                    image_valid_reg && image_sel_reg;
            else if (eeprom_load_in)
                cfg_reg.led_mapping_select <=
                    eeprom_present_in && eeprom_led_select_in;
        end
    end

    // ======================================================
    // led mapping; leds are active low on the pin
    always_comb
    begin
        // full duplex is left to software via gpio mode
        led_pin8_level = ~status_in.activity;
        led_pin9_level = ~status_in.link;
        if (!cfg_reg.led_mapping_select)
            led_pin9_level = ~(status_in.link
                && !status_in.activity);
    end

    assign drv10 = pin_drive(cfg_reg.pin10_function,
        cfg_reg.pin_buffer_type[2], cfg_reg.pin_direction[2],
        cfg_reg.pin_data[2], ~status_in.speed,
        mii_in.rxd[0], mii_in.rxd[3]);
    assign drv9 = pin_drive(cfg_reg.pin9_function,
        cfg_reg.pin_buffer_type[1], cfg_reg.pin_direction[1],
        cfg_reg.pin_data[1], led_pin9_level,
        mii_in.rxd[1], mii_in.phy_reset_low_mirror);
    assign drv8 = pin_drive(cfg_reg.pin8_function,
        cfg_reg.pin_buffer_type[0], cfg_reg.pin_direction[0],
        cfg_reg.pin_data[0], led_pin8_level,
        mii_in.rxd[2], mii_in.crs);

    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pin_out <= 3'h0;
            pin_oe_out <= 3'h0;
        end
        else
        begin
            pin_out <= {drv10[1], drv9[1], drv8[1]};
            pin_oe_out <= {drv10[0], drv9[0], drv8[0]};
        end
    end

    // ======================================================
    // wake: any level change on an enabled gpio input
    // hold off until the synchroniser and pin_prev_reg carry real levels
    assign wake_hits = {cfg_reg.pin10_function == LPC_FN_GPIO,
        cfg_reg.pin9_function == LPC_FN_GPIO,
        cfg_reg.pin8_function == LPC_FN_GPIO}
        & ~cfg_reg.pin_direction & wake_enable_in
        & (pin_lvl ^ pin_prev_reg)
        & {3{settle_reg == LPC_WAKE_SETTLE}};

    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pin_prev_reg <= 3'h0;
            settle_reg <= 2'h0;
            wake_event_out <= 1'b0;
        end
        else
        begin
            pin_prev_reg <= pin_lvl;
            if (settle_reg != LPC_WAKE_SETTLE)
                settle_reg <= settle_reg + 2'h1;
            wake_event_out <= |wake_hits;
        end
    end

    // ======================================================
    // checks
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence setup_s;
        psel_in && !penable_in;
    endsequence
    sequence access_s;
        psel_in && penable_in && !pready_out;
    endsequence

    apb_one_wait_a: assert property (setup_s ##1 access_s
        |=> pready_out) else $error("pready not one cycle after access");
    rsv_zero_a: assert property (pready_out && !pslverr_out
        |-> (prdata_out & 32'h7ccc_f888) == 32'h0)
        else $error("reserved bits not zero");
    read_live_a: assert property (access && !pready_out && hit
        && !pwrite_in |=> prdata_out[2:0] == $past(pin_lvl))
        else $error("data read not live pin level");
    restore_sel_a: assert property (lite_reset_in
        || usb_reset_in |=> cfg_reg.led_mapping_select ==
        ($past(image_valid_reg) && $past(image_sel_reg)))
        else $error("mapping not restored");
    fn10_write_a: assert property (done && hit && pwrite_in
        && pstrb_in[3] |=> cfg_reg.pin10_function ==
        $past(pwdata_in[25:24]))
        else $error("pin10 function not written");
    gpio_out_a: assert property (cfg_reg.pin_direction[0]
        && cfg_reg.pin8_function == LPC_FN_GPIO && cfg_reg.pin_buffer_type[0]
        |=> pin_oe_out[0] && pin_out[0] == $past(cfg_reg.pin_data[0]))
        else $error("pin8 push-pull output wrong");
    input_off_a: assert property (!cfg_reg.pin_direction[1]
        && cfg_reg.pin9_function == LPC_FN_GPIO |=> !pin_oe_out[1])
        else $error("input pin9 driven");
    od_high_a: assert property (!cfg_reg.pin_buffer_type[2]
        |=> !pin_out[2]) else $error("open-drain pin10 drove high");
    mirror_crs_a: assert property (cfg_reg.pin_buffer_type[0]
        && cfg_reg.pin8_function == LPC_FN_MIRROR_B
        |=> pin_oe_out[0] && pin_out[0] == $past(mii_in.crs))
        else $error("crs mirror wrong");
    led_map_a: assert property (cfg_reg.led_mapping_select
        && cfg_reg.pin9_function == LPC_FN_LED && cfg_reg.pin_buffer_type[1]
        |=> pin_out[1] == !$past(status_in.link))
        else $error("pin9 led not link in mapping 1");
    wake_gate_a: assert property (wake_event_out |->
        |($past(wake_enable_in) & ~$past(cfg_reg.pin_direction)))
        else $error("wake without enable and input");

endmodule

// *** verif/ledpc_load.sv ***
/*
 * ledpc_load: board-side model of pins 8, 9 and 10, with pull-ups
 * and an optional external driver per pin.
 * assumes: device drive wins over the external driver.
 */
`timescale 1ns/10ps

module ledpc_load (
    input wire logic [2:0] pin_out_in,
    input wire logic [2:0] pin_oe_in,
    input wire logic [2:0] ext_en_in,
    input wire logic [2:0] ext_val_in,
    output logic [2:0] pin_level_out
);
    // ======================================================
    // wire level
    // a released, undriven pin floats high through its pull-up
    always_comb
    begin
        pin_level_out = (pin_oe_in & pin_out_in)
            | (~pin_oe_in & ~ext_en_in)
            | (~pin_oe_in & ext_en_in & ext_val_in);
    end
endmodule

// *** verif/test_led_gpio_pin_config.sv ***
/*
 * test_led_gpio_pin_config: self-checking bench for ledpc_top.
 * assumes: apb slave answers with pready; pins resolved by ledpc_load.
 */
`timescale 1ns/10ps

module test_led_gpio_pin_config;
    import ledpc_pkg::*;
    localparam logic [31:0] MASK = 32'h8333_0770;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, wake;
    logic [31:0] prdata;
    logic [2:0] pin_out, pin_oe, pin_lvl;
    ledpc_status_s st = '0;
    ledpc_mii_s mi = '0;
    logic [2:0] wen = 3'h7;
    logic [2:0] ext_en = 3'h0;
    logic [2:0] ext_val = 3'h0;
    logic ee_ld = 1'b0;
    logic ee_pr = 1'b0;
    logic ee_sel = 1'b0;
    logic usb_r = 1'b0;
    logic lite_r = 1'b0;
    logic [32:0] exp_q[$];
    logic [31:0] c;
    int error_cnt = 0;
    int n_tests = 0;
    int wake_cnt = 0;
    int w0;

    ledpc_top uut (.mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(pstrb), .pready_out(pready),
        .pslverr_out(pslverr), .prdata_out(prdata), .pin_in(pin_lvl),
        .pin_out(pin_out), .pin_oe_out(pin_oe), .status_in(st),
        .mii_in(mi), .wake_enable_in(wen), .eeprom_load_in(ee_ld),
        .eeprom_present_in(ee_pr), .eeprom_led_select_in(ee_sel),
        .usb_reset_in(usb_r), .lite_reset_in(lite_r),
        .wake_event_out(wake));
    ledpc_load load (.pin_out_in(pin_out), .pin_oe_in(pin_oe),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_level_out(pin_lvl));

    initial
    begin
        forever #25 mclk_in = ~mclk_in;
    end

    // ======================================================
    // checking and closing
    task automatic chk(string name, logic [32:0] seen, logic [32:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge mclk_in)
    begin
        if (pready === 1'b1 && psel && pen && !pwr)
        begin
            if (exp_q.size() == 0)
                chk("unexpected read", 33'h0, 33'h1);
            else
                chk("read", {pslverr, prdata}, exp_q.pop_front());
        end
        if (wake === 1'b1)
            wake_cnt++;
    end

    // ======================================================
    // apb master
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d,
        logic [3:0] s);
        int n;
        n = 0;
        @(posedge mclk_in);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk_in);
        pen <= 1'b1;
        do
        begin
            @(posedge mclk_in);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1)
        begin
            error_cnt++;
            tally_and_finish();
        end
    endtask

    task automatic rd(logic [11:0] a, logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0, 4'hf);
    endtask

    // ======================================================
    // expected pin drive {oe, out} for a register value
    function automatic logic [5:0] exp_pins(logic [31:0] v);
        logic [1:0] fn;
        logic lv;
        logic drv;
        logic [5:0] r;
        r = '0;
        for (int p = 0; p < 3; p++)
        begin
            fn = v[16+4*p +: 2];
            case (fn)
                2'h0: lv = v[p];
                2'h1: lv = (p == 2) ? ~st.speed : (p == 0) ? ~st.activity
                    : v[31] ? ~st.link : ~(st.link & ~st.activity);
                2'h2: lv = mi.rxd[2-p];
                default: lv = (p == 2) ? mi.rxd[3] : (p == 1)
                    ? mi.phy_reset_low_mirror : mi.crs;
            endcase
            drv = (fn != 2'h0) || v[4+p];
            r[3+p] = drv & (v[8+p] | ~lv);
            r[p] = drv & v[8+p] & lv;
        end
        return r;
    endfunction

    task automatic chk_cfg(logic [31:0] v);
        logic [5:0] e;
        logic [2:0] lv;
        repeat (3) @(posedge mclk_in);
        e = exp_pins(v);
        lv = (e[5:3] & e[2:0]) | (~e[5:3] & ~ext_en)
            | (~e[5:3] & ext_en & ext_val);
        chk("pin oe", {30'h0, pin_oe}, {30'h0, e[5:3]});
        chk("pin levels", {30'h0, pin_out},
            {30'h0, e[2:0]});
        rd(LPC_CFG_ADDR,
            {1'b0, (v & MASK) | lv});
    endtask

    task automatic pulse(logic [2:0] which);
        @(posedge mclk_in);
        {ee_ld, usb_r, lite_r} <= which;
        @(posedge mclk_in);
        {ee_ld, usb_r, lite_r} <= 3'h0;
    endtask

    // ======================================================
    // main sequence
    initial
    begin
        void'($urandom(38));
        repeat (6) @(posedge mclk_in);
        rstn_in <= 1'b1;
        chk_cfg(32'h0);
        chk("wake after reset", 33'(wake_cnt), 33'h0);
        apb(1'b1, LPC_CFG_ADDR, 32'hffffffff, 4'h1);
        chk_cfg(32'h0000_0077);
        apb(1'b1, LPC_CFG_ADDR, 32'h7ccc_f888, 4'hf);
        chk_cfg(32'h7ccc_f888);
        $display("test reset and strobes done");
        for (int i = 0; i < 16; i++)
        begin
            c = $urandom;
            c[31] = i[3];
            c[25:24] = i[2:1];
            c[21:20] = i[2:1];
            c[17:16] = i[2:1];
            c[10:8] = {3{i[0]}};
            st <= ledpc_status_s'($urandom);
            mi <= ledpc_mii_s'($urandom);
            apb(1'b1, LPC_CFG_ADDR, c, 4'hf);
            chk_cfg(c);
        end
        $display("test functions done");
        rd(12'h028, {1'b1, 32'h0});
        apb(1'b1, 12'h028, 32'hffffffff, 4'hf);
        chk_cfg(c);
        $display("test unmapped done");
        apb(1'b1, LPC_CFG_ADDR, 32'h0, 4'hf);
        ee_pr <= 1'b1;
        ee_sel <= 1'b1;
        pulse(3'b100);
        chk_cfg(32'h8000_0000);
        apb(1'b1, LPC_CFG_ADDR, 32'h0, 4'hf);
        pulse(3'b010);
        chk_cfg(32'h8000_0000);
        ee_pr <= 1'b0;
        pulse(3'b100);
        apb(1'b1, LPC_CFG_ADDR, 32'h8000_0000, 4'hf);
        pulse(3'b001);
        chk_cfg(32'h0);
        $display("test mapping reload done");
        // pins stay inputs before any wake use
        wen <= 3'b001;
        ext_en <= 3'b111;
        ext_val <= 3'b000;
        repeat (8) @(posedge mclk_in);
        w0 = wake_cnt;
        ext_val <= 3'b001;
        repeat (8) @(posedge mclk_in);
        chk("wake enabled", 33'(wake_cnt - w0), 33'h1);
        ext_val <= 3'b011;
        repeat (8) @(posedge mclk_in);
        chk("wake disabled", 33'(wake_cnt - w0), 33'h1);
        chk_cfg(32'h0);
        wen <= 3'b011;
        apb(1'b1, LPC_CFG_ADDR, 32'h0000_0220, 4'hf);
        repeat (8) @(posedge mclk_in);
        chk("wake output", 33'(wake_cnt - w0), 33'h1);
        $display("test wake done");
        tally_and_finish();
    end
endmodule
